//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int FC = 200;
	localparam int PC = 20;
	logic clk_i, rst_n_i, sel_i, cs_n, cd, wr_n, rd_n, sclk, si, so, int_o, we, rd, oe, smode, idone, gmode;
	logic [1:0] cg;
	logic [7:0] pdi, pdo, hbus, wd, rdat;
	logic [10:0] addr;
	logic [7:0] mem [0:2047];
	logic [31:0] rb, d;
	int n_errors, compares, cyc, k;
	// Bus level from both drivers, memory beside the block
	assign pdi = oe ? pdo : hbus;
	assign rdat = mem[addr];
	always @(posedge clk_i) begin
		if (we)
			mem[addr] <= wd;
	end
	vmh_host_if #(.FRAME_CYC(FC), .PULSE_CYC(PC)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_i(sel_i),
		.cs_n_i(cs_n), .cd_i(cd), .wr_n_i(wr_n), .rd_n_i(rd_n), .parallel_data_bus_i(pdi),
		.parallel_data_bus_o(pdo), .parallel_data_bus_oe_o(oe), .sclk_i(sclk), .si_i(si), .so_o(so),
		.int_o(int_o), .mem_we_o(we), .mem_rd_o(rd), .mem_addr_o(addr), .mem_wdata_o(wd), .mem_rdata_i(rdat),
		.serial_mode_o(smode), .init_done_o(idone), .gray_mode_o(gmode), .char_gray_o(cg));
	vmh_host_model h_u (.ser_i(!sel_i), .bus_i(pdi), .so_i(so), .cs_n_o(cs_n), .cd_o(cd), .wr_n_o(wr_n),
		.rd_n_o(rd_n), .sclk_o(sclk), .si_o(si), .bus_o(hbus));
	// Core clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Cycle ceiling against a hang
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			n_errors++;
			$display("[ERR] %0t timeout", $time);
			tally_and_finish;
		end
	end
	task automatic tally_and_finish;
		if (n_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic put(input logic c, input logic [7:0] b);
		h_u.phase(c, 1'b0, 1, 8, {24'h00_0000, b}, rb);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] p);
		put(1'b1, c);
		put(1'b0, p);
	endtask
	// Parallel pass, then serial pass
	initial begin
		rst_n_i = 1'b0;
		sel_i = 1'b1;
		for (int s = 1; s >= 0; s--) begin
			@(posedge clk_i);
			rst_n_i <= 1'b0;
			sel_i <= s[0];
			repeat (6) @(posedge clk_i);
			rst_n_i <= 1'b1;
			repeat (8) @(posedge clk_i);
			d = s ? 32'h0021_AA55 : 32'h003C_5A96;
			chk(24'(smode), 24'(!s[0]));
			if (s == 0)
				h_u.phase(1'b1, 1'b0, 1, 3, 32'hFF, rb);
			cmd(8'h24, 8'h01);
			chk(24'({idone, cg}), 24'h00_0000);
			cmd(8'h14, 8'h10);
			cmd(8'h24, 8'h01);
			chk(24'({idone, gmode, cg}), 24'h00_0008);
			cmd(8'h14, 8'h14);
			for (int p = 0; p < 4; p++) begin
				cmd(8'h24, p[7:0]);
				chk(24'({gmode, cg}), 24'(p < 3 ? 4 + p : 6));
			end
			// Write across the top of memory, then read back
			cmd(8'h0E, 8'hFE);
			cmd(8'h0F, 8'h07);
			put(1'b1, 8'h08);
			h_u.phase(1'b0, 1'b0, 3, 8, d, rb);
			chk({mem[11'h000], mem[11'h7FF], mem[11'h7FE]}, d[23:0]);
			cmd(8'h0E, 8'hFE);
			cmd(8'h0F, 8'h07);
			put(1'b1, 8'h09);
			h_u.phase(1'b0, 1'b1, 3, 8, 32'hFFFF_FFFF, rb);
			chk(rb[23:0], {d[15:0], 8'h00});
			// Frame pulse in each output mode
			for (int m = 0; m < 3; m++) begin
				cmd(8'h15, m == 2 ? 8'h03 : 8'(m));
				// Undefined command 0A begun inside the active pulse; the block must ignore it
				if (m != 0) begin
					wait (int_o === (m == 1));
					cmd(8'h0A, 8'h3E);
				end
				k = 0;
				// Counted on the falling edge, away from the edge that launches the level
				repeat (FC) @(negedge clk_i) k += (int_o === 1'b1);
				chk(24'(k), 24'(m == 0 ? 0 : m == 1 ? PC : FC - PC));
			end
			chk(24'({idone, gmode, cg}), 24'h00_000E);
		end
		tally_and_finish;
	end
endmodule
bind vmh_host_if vmh_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sel_i(sel_i), .rd_n_i(rd_n_i),
	.mem_we_o(mem_we_o), .mem_rd_o(mem_rd_o), .int_o(int_o), .parallel_data_bus_oe_o(parallel_data_bus_oe_o),
	.serial_mode_o(serial_mode_o), .init_done_o(init_done_o), .gray_mode_o(gray_mode_o),
	.char_gray_o(char_gray_o));
`default_nettype wire

//--- vmh_host_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "vmh_params.svh"

module vmh_host_if #(
	parameter int FRAME_CYC = (`VMH_FRAME_NS * `VMH_CLK_MHZ) / 1000,
	parameter int PULSE_CYC = (`VMH_PULSE_NS * `VMH_CLK_MHZ) / 1000
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Interface strap
	input wire logic sel_i,
	// Shared select pins
	input wire logic cs_n_i,
	input wire logic cd_i,
	// Parallel strobe bus
	input wire logic wr_n_i,
	input wire logic rd_n_i,
	input wire logic [7:0] parallel_data_bus_i,
	output logic [7:0] parallel_data_bus_o,
	output logic parallel_data_bus_oe_o,
	// Serial link
	input wire logic sclk_i,
	input wire logic si_i,
	output logic so_o,
	// Frame interrupt
	output logic int_o,
	// Display memory port
	output logic mem_we_o,
	output logic mem_rd_o,
	output logic [10:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	input wire logic [7:0] mem_rdata_i,
	// Status
	output logic serial_mode_o,
	output logic init_done_o,
	output logic gray_mode_o,
	output logic [1:0] char_gray_o
);

	// Address step with wrap at the top of memory
	function automatic logic [10:0] vmh_next_addr(input logic [10:0] a);
		if (a == `VMH_ADDR_LAST) begin
			return `VMH_ADDR_RST;
		end
		return a + 11'h001;
	endfunction

	// Pin synchronisers: {tgl, sel, cd, cs_n, rd_n, wr_n, data}
	logic [13:0] sync1_r;
	logic [13:0] sync2_r;
	logic [13:0] sync3_r;
	logic ser_tgl;
	logic [7:0] ser_rx_byte;

	logic strap_done_r;
	logic serial_r;
	logic cd_lat_r;
	logic init_r;
	logic gray_r;
	logic [1:0] char_gray_r;
	logic [1:0] int_mode_r;
	vmh_pkg::vmh_phase_t phase_r;
	logic [10:0] addr_r;
	logic [7:0] addr_lo_r;
	logic [7:0] tx_byte_r;
	logic fetch_r;
	logic mem_we_r;
	logic [10:0] mem_addr_r;
	logic [7:0] mem_wdata_r;
	logic pbus_oe_r;
	logic [7:0] pbus_r;
	logic [20:0] frame_cnt_r;
	logic int_r;

	// Serial shifter on the link clock
	vmh_serial_link u_link (
		.sclk_i(sclk_i),
		.cs_n_i(cs_n_i),
		.si_i(si_i),
		.rst_n_i(rst_n_i),
		.tx_byte_i(tx_byte_r),
		.rx_byte_o(ser_rx_byte),
		.done_tgl_o(ser_tgl),
		.so_o(so_o)
	);

	// Two-flop synchronisers plus one history stage for edges
	always_ff @(posedge clk_i) begin
		sync1_r <= {ser_tgl, sel_i, cd_i, cs_n_i, rd_n_i, wr_n_i, parallel_data_bus_i};
		sync2_r <= sync1_r;
		sync3_r <= sync2_r;
	end

	logic tgl_s;
	logic sel_s;
	logic cd_s;
	logic cs_s;
	logic rd_s;
	logic wr_s;
	logic [7:0] pdata_s;
	logic tgl_d;
	logic cs_d;
	logic rd_d;
	logic wr_d;

	// Synchronised views
	assign tgl_s = sync2_r[13];
	assign sel_s = sync2_r[12];
	assign cd_s = sync2_r[11];
	assign cs_s = sync2_r[10];
	assign rd_s = sync2_r[9];
	assign wr_s = sync2_r[8];
	assign pdata_s = sync2_r[7:0];
	assign tgl_d = sync3_r[13];
	assign cs_d = sync3_r[10];
	assign rd_d = sync3_r[9];
	assign wr_d = sync3_r[8];

	logic reading;
	logic wr_ev;
	logic rd_rise_ev;
	logic ser_ev;
	logic in_ev;
	logic in_cmd;
	logic [7:0] in_data;
	logic out_ev;

	// Byte events from whichever interface the strap picked
	assign reading = (phase_r == vmh_pkg::VMH_PH_READ);
	assign wr_ev = !serial_r && !cs_s && wr_s && !wr_d;
	assign rd_rise_ev = !serial_r && !cs_s && rd_s && !rd_d;
	assign ser_ev = serial_r && (tgl_s != tgl_d);
	assign in_ev = wr_ev || (ser_ev && !(reading && !cd_lat_r));
	assign in_cmd = serial_r ? cd_lat_r : cd_s;
	assign in_data = serial_r ? ser_rx_byte : pdata_s;
	assign out_ev = (rd_rise_ev && reading) || (ser_ev && reading && !cd_lat_r);

	// Strap caught once after reset release
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			strap_done_r <= 1'b0;
			serial_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			serial_r <= !sel_s;
		end
	end

	// Command/data flag taken as select falls
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cd_lat_r <= 1'b0;
		end else if (!cs_s && cs_d) begin
			cd_lat_r <= cd_s;
		end
	end

	// Command decode and phase tracking
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			phase_r <= vmh_pkg::VMH_PH_NONE;
		end else if (in_ev && in_cmd) begin
			if (!init_r && in_data != `VMH_CMD_MODE) begin
				phase_r <= vmh_pkg::VMH_PH_NONE;
			end else begin
				unique case (in_data)
					`VMH_CMD_MODE: phase_r <= vmh_pkg::VMH_PH_MODE;
					`VMH_CMD_INTMODE: phase_r <= vmh_pkg::VMH_PH_INTM;
					`VMH_CMD_BRIGHT: phase_r <= vmh_pkg::VMH_PH_BRIGHT;
					`VMH_CMD_ADDR_LO: phase_r <= vmh_pkg::VMH_PH_ADDR_LO;
					`VMH_CMD_ADDR_HI: phase_r <= vmh_pkg::VMH_PH_ADDR_HI;
					`VMH_CMD_WRITE: phase_r <= vmh_pkg::VMH_PH_WRITE;
					`VMH_CMD_READ: phase_r <= vmh_pkg::VMH_PH_READ;
					default: phase_r <= vmh_pkg::VMH_PH_NONE;
				endcase
			end
		end else if (in_ev && phase_r != vmh_pkg::VMH_PH_WRITE && phase_r != vmh_pkg::VMH_PH_READ) begin
			phase_r <= vmh_pkg::VMH_PH_NONE;
		end
	end

	// Configuration parameters
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			init_r <= 1'b0;
			gray_r <= 1'b0;
			char_gray_r <= `VMH_RST_CHAR_GRAY;
			int_mode_r <= `VMH_RST_INT_MODE;
		end else if (in_ev && !in_cmd) begin
			if (phase_r == vmh_pkg::VMH_PH_MODE) begin
				if (in_data == `VMH_MODE_MONO || in_data == `VMH_MODE_GRAY) begin
					gray_r <= (in_data == `VMH_MODE_GRAY);
					init_r <= 1'b1;
				end
			end
			if (phase_r == vmh_pkg::VMH_PH_INTM) begin
				if (in_data == `VMH_INT_OFF || in_data == `VMH_INT_POS || in_data == `VMH_INT_NEG) begin
					int_mode_r <= in_data[1:0];
				end
			end
			if (phase_r == vmh_pkg::VMH_PH_BRIGHT && gray_r && in_data <= `VMH_BRIGHT_MAX) begin
				char_gray_r <= in_data[1:0];
			end
		end
	end

	// Memory pointer, writes and read fetches
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			addr_r <= `VMH_ADDR_RST;
			addr_lo_r <= 8'h00;
			tx_byte_r <= `VMH_DUMMY_BYTE;
			fetch_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= `VMH_ADDR_RST;
			mem_wdata_r <= 8'h00;
		end else begin
			mem_we_r <= 1'b0;
			fetch_r <= 1'b0;
			if (fetch_r) begin
				tx_byte_r <= mem_rdata_i;
				addr_r <= vmh_next_addr(addr_r);
			end
			if (in_ev && in_cmd && init_r && in_data == `VMH_CMD_READ) begin
				tx_byte_r <= `VMH_DUMMY_BYTE;
			end else if (in_ev && !in_cmd) begin
				if (phase_r == vmh_pkg::VMH_PH_ADDR_LO) begin
					addr_lo_r <= in_data;
				end
				if (phase_r == vmh_pkg::VMH_PH_ADDR_HI) begin
					addr_r <= {in_data[10 - `VMH_ADDR_HI_LSB:0], addr_lo_r};
				end
				if (phase_r == vmh_pkg::VMH_PH_WRITE) begin
					mem_we_r <= 1'b1;
					mem_addr_r <= addr_r;
					mem_wdata_r <= in_data;
					addr_r <= vmh_next_addr(addr_r);
				end
			end else if (out_ev) begin
				mem_addr_r <= addr_r;
				fetch_r <= 1'b1;
			end
		end
	end

	// Parallel read drive while read strobe and select are low
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pbus_oe_r <= 1'b0;
			pbus_r <= 8'h00;
		end else begin
			pbus_oe_r <= !serial_r && !cs_s && !rd_s;
			pbus_r <= tx_byte_r;
		end
	end

	// Frame timer and pulse window
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			frame_cnt_r <= 21'h0_0000;
		end else if (frame_cnt_r == 21'(FRAME_CYC - 1)) begin
			frame_cnt_r <= 21'h0_0000;
		end else begin
			frame_cnt_r <= frame_cnt_r + 21'h0_0001;
		end
	end

	logic pulse;
	assign pulse = (frame_cnt_r < 21'(PULSE_CYC));

	// Interrupt polarity per mode
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			int_r <= 1'b0;
		end else if (int_mode_r == `VMH_INT_POS) begin
			int_r <= pulse;
		end else if (int_mode_r == `VMH_INT_NEG) begin
			int_r <= !pulse;
		end else begin
			int_r <= 1'b0;
		end
	end

	// Outputs straight from flops
	assign parallel_data_bus_o = pbus_r;
	assign parallel_data_bus_oe_o = pbus_oe_r;
	assign int_o = int_r;
	assign mem_we_o = mem_we_r;
	assign mem_rd_o = fetch_r;
	assign mem_addr_o = mem_addr_r;
	assign mem_wdata_o = mem_wdata_r;
	assign serial_mode_o = serial_r;
	assign init_done_o = init_r;
	assign gray_mode_o = gray_r;
	assign char_gray_o = char_gray_r;

endmodule

`default_nettype wire

//--- vmh_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module vmh_host_model (
	// Mode and read back
	input wire logic ser_i,
	input wire logic [7:0] bus_i,
	input wire logic so_i,
	// Host pins
	output logic cs_n_o,
	output logic cd_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic sclk_o,
	output logic si_o,
	output logic [7:0] bus_o
);
	// Idle: select and strobes high, link clock parked high
	initial begin
		{cs_n_o, cd_o, wr_n_o, rd_n_o, sclk_o, si_o} = 6'b101110;
		bus_o = 8'h00;
	end
	// One select period of n units, nb bits each on the link
	task automatic phase(input logic c, input logic rd, input int n, input int nb, input logic [31:0] t,
			output logic [31:0] r);
		r = 32'h0;
		// Start a quarter core period after the call so no pin moves on a core clock edge
		#1.25;
		cd_o = c;
		#20 cs_n_o = 1'b0;
		#40;
		for (int k = 0; k < n; k++) begin
			if (ser_i) begin
				for (int i = 0; i < nb; i++) begin
					sclk_o = 1'b0;
					si_o = t[8 * k + i];
					#7.5 sclk_o = 1'b1;
					r[8 * k + i] = so_i;
					#7.5;
				end
			end else if (rd) begin
				rd_n_o = 1'b0;
				#100 r[8 * k +: 8] = bus_i;
				rd_n_o = 1'b1;
			end else begin
				bus_o = t[8 * k +: 8];
				#20 wr_n_o = 1'b0;
				#100 wr_n_o = 1'b1;
				#40 bus_o = ~bus_o;
			end
			si_o = ~si_o;
			#1000;
		end
		cs_n_o = 1'b1;
		#398.75;
	endtask
endmodule
`default_nettype wire

//--- vmh_params.svh
`ifndef VMH_PARAMS_SVH
`define VMH_PARAMS_SVH

// Command codes
`define VMH_CMD_WRITE 8'h08
`define VMH_CMD_READ 8'h09
`define VMH_CMD_ADDR_LO 8'h0E
`define VMH_CMD_ADDR_HI 8'h0F
`define VMH_CMD_MODE 8'h14
`define VMH_CMD_INTMODE 8'h15
`define VMH_CMD_BRIGHT 8'h24

// Parameter values
`define VMH_MODE_MONO 8'h10
`define VMH_MODE_GRAY 8'h14
`define VMH_INT_OFF 8'h00
`define VMH_INT_POS 8'h01
`define VMH_INT_NEG 8'h03
`define VMH_BRIGHT_MAX 8'h02
`define VMH_DUMMY_BYTE 8'h00

// Address field
`define VMH_ADDR_HI_LSB 8
`define VMH_ADDR_LAST 11'h7FF
`define VMH_ADDR_RST 11'h000

// Reset values
`define VMH_RST_CHAR_GRAY 2'h0
`define VMH_RST_INT_MODE 2'h0

// Timing
`define VMH_CLK_MHZ 200
`define VMH_FRAME_NS 8400000
`define VMH_PULSE_NS 65000

`endif

//--- vmh_pkg.sv
package vmh_pkg;

	// Phase of the command interpreter: which byte a data byte belongs to
	typedef enum logic [2:0] {
		VMH_PH_NONE = 3'b000,
		VMH_PH_MODE = 3'b001,
		VMH_PH_INTM = 3'b010,
		VMH_PH_BRIGHT = 3'b011,
		VMH_PH_ADDR_LO = 3'b100,
		VMH_PH_ADDR_HI = 3'b101,
		VMH_PH_WRITE = 3'b110,
		VMH_PH_READ = 3'b111
	} vmh_phase_t;

endpackage

//--- vmh_props.sv
`timescale 1ns/1ps
`default_nettype none
module vmh_props (
	// Clock, reset and pins
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sel_i,
	input wire logic rd_n_i,
	// Watched outputs
	input wire logic mem_we_o,
	input wire logic mem_rd_o,
	input wire logic int_o,
	input wire logic parallel_data_bus_oe_o,
	input wire logic serial_mode_o,
	input wire logic init_done_o,
	input wire logic gray_mode_o,
	input wire logic [1:0] char_gray_o
);
	// All checks run on the core clock
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// Interface choice and bus ownership
	strap_map_a: assert property ($stable(sel_i) [*5] |-> serial_mode_o == !sel_i)
		else $error("strap");
	oe_serial_a: assert property (serial_mode_o |-> !parallel_data_bus_oe_o)
		else $error("oe in serial");
	oe_release_a: assert property (rd_n_i [*4] |-> !parallel_data_bus_oe_o)
		else $error("oe stuck");
	// Memory strobes are single pulses, only after init
	we_pulse_a: assert property (mem_we_o |=> !mem_we_o)
		else $error("we long");
	rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o)
		else $error("rd long");
	init_gate_a: assert property (mem_we_o || mem_rd_o || gray_mode_o |-> init_done_o)
		else $error("no init");
	// Brightness moves only in gray mode and stays in range
	bright_gate_a: assert property ($changed(char_gray_o) |-> gray_mode_o)
		else $error("mono bright");
	bright_range_a: assert property (gray_mode_o |-> char_gray_o != 2'h3)
		else $error("bright range");
	// Main scenarios reached
	cover property (mem_we_o);
	cover property (mem_rd_o);
	cover property ($rose(int_o));
endmodule
`default_nettype wire

//--- vmh_serial_link.sv
`timescale 1ns/1ps
`default_nettype none

module vmh_serial_link (
	// Link pins
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic rst_n_i,
	// Byte to send, held stable by the core for a whole byte
	input wire logic [7:0] tx_byte_i,
	// Received byte and its completion toggle
	output logic [7:0] rx_byte_o,
	output logic done_tgl_o,
	output logic so_o
);

	logic [2:0] bit_cnt_r;
	logic [7:0] shift_r;

	// Bit counter cleared while the select is high
	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt_r <= 3'h0;
		end else begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
		end
	end

	// Shift in on rising edge, first bit ends up in bit 0
	always_ff @(posedge sclk_i) begin
		shift_r <= {si_i, shift_r[7:1]};
	end

	// Complete byte held until the next one is done
	always_ff @(posedge sclk_i) begin
		if (bit_cnt_r == 3'h7) begin
			rx_byte_o <= {si_i, shift_r[7:1]};
		end
	end

	// One toggle per finished byte, read or written
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_tgl_o <= 1'b0;
		end else if (!cs_n_i && bit_cnt_r == 3'h7) begin
			done_tgl_o <= ~done_tgl_o;
		end
	end

	// Output bit updated on falling edge, low bit first
	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			so_o <= 1'b0;
		end else begin
			so_o <= tx_byte_i[bit_cnt_r];
		end
	end

endmodule

`default_nettype wire
